// File: common/drive_defines.svh
// Constants shared by the drive end and the controller end
`ifndef DRIVE_DEFINES_SVH
`define DRIVE_DEFINES_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS        50
`define PREP_TIME_MS         250
`define PREP_CYCLES          (`PREP_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define MIN_CYCLE_US         1000
`define MIN_CYCLE_CYCLES     (`MIN_CYCLE_US * 1000 / `CLK_PERIOD_NS)
`define INIT_CYCLES          16

// ---------------------------------------------------------------
// Shared-clock cycle codes (units of 0.25 ms)
// ---------------------------------------------------------------
`define DC_CODE_250US        8'h01
`define DC_CODE_500US        8'h02
`define DC_CODE_1MS          8'h04
`define DC_CODE_10MS         8'h28

// ---------------------------------------------------------------
// Emergency message fields
// ---------------------------------------------------------------
`define EMCY_CODE_ALARM      16'hFF00
`define EMCY_CODE_ESM        16'hA000
`define EMCY_CHANNEL         8'h02
`define EMCY_DIAG_FIRST      8'h0A
`define EMCY_ZERO_BYTE       8'h00

// ---------------------------------------------------------------
// Control word bits
// ---------------------------------------------------------------
`define CW_SWITCH_ON         0
`define CW_ENABLE_VOLTAGE    1
`define CW_QUICK_STOP_N      2
`define CW_ENABLE_OP         3
`define CW_FAULT_RESET       7

// ---------------------------------------------------------------
// Status word bits
// ---------------------------------------------------------------
`define SW_READY             0
`define SW_SWITCHED_ON       1
`define SW_OP_ENABLED        2
`define SW_FAULT             3
`define SW_VOLTAGE           4
`define SW_QUICK_STOP_N      5
`define SW_SWITCH_DISABLED   6

`endif

// File: common/drive_pkg.sv
// Types shared by the drive end and the controller end
package drive_pkg;
    typedef enum logic [1:0] {
        SYNC_FREE_RUN = 2'b00,
        SYNC_SM2      = 2'b01,
        SYNC_SHARED   = 2'b10
    } sync_mode_type;

    typedef enum logic [7:0] {
        ST_NOT_READY   = 8'b0000_0001,
        ST_SW_DISABLED = 8'b0000_0010,
        ST_READY       = 8'b0000_0100,
        ST_SWITCHED_ON = 8'b0000_1000,
        ST_OP_ENABLED  = 8'b0001_0000,
        ST_QUICK_STOP  = 8'b0010_0000,
        ST_FAULT_REACT = 8'b0100_0000,
        ST_FAULT       = 8'b1000_0000
    } drive_state_type;

    typedef logic [63:0] emcy_msg_type;
endpackage

// File: common/drive_link_if.sv
// Link between the drive and the fieldbus controller
`timescale 1ns/1ns
interface drive_link_if;
    logic                  rx_frame;     // Frame arrived (pulse)
    logic                  sync0;        // Shared-clock pulse
    logic [15:0]           control_word;
    logic [15:0]           status_word;
    logic                  safeop_req;   // Pre-Op to Safe-Op request (pulse)
    logic                  safeop_ack;   // Request granted (pulse)
    logic                  safeop_nak;   // Request refused (pulse)
    logic                  param_wr;     // Parameter write (pulse)
    logic                  param_rej;    // Parameter write refused (pulse)
    logic                  emcy_valid;
    logic                  emcy_ready;
    drive_pkg::emcy_msg_type emcy_data;

    modport drive_mp (
        input  rx_frame, sync0, control_word, safeop_req, param_wr, emcy_ready,
        output status_word, safeop_ack, safeop_nak, param_rej, emcy_valid, emcy_data
    );
    modport ctrl_mp (
        output rx_frame, sync0, control_word, safeop_req, param_wr, emcy_ready,
        input  status_word, safeop_ack, safeop_nak, param_rej, emcy_valid, emcy_data
    );
endinterface

// File: design/drive_end.sv
// Drive end: sync mode, emergency messages, drive state machine
`timescale 1ns/1ns
`include "drive_defines.svh"

// Behaviour
// RQ1: Free run steps without bus, cycle >=1ms
// RQ2: SM2 mode steps on each receive frame
// RQ3: Controller keeps SM2 cycle at least 1ms
// RQ4: Shared-clock cycle 0.25, 0.5, 1..10 ms
// RQ5: Shared-clock mode steps on each sync0
// RQ6: One emergency per error while it persists
// RQ7: Emergency message is eight bytes
// RQ8: Alarm emergency code is FF00h
// RQ9: Byte 2 carries error register
// RQ10: Byte 4 alarm code, others zero
// RQ11: Safe-Op failure sends A000h, 02h, 0Ah
// RQ12: Refuse Safe-Op on bad cycle or mapping
// RQ13: Control word drives, status word reports
// RQ14: Initialising: unexcited, parameter writes refused
// RQ15: Excite only when operation enabled; code also excites in quick stop and fault reaction
// RQ16: Quick stop keeps motor excited while stopping
// RQ17: Alarm: fault reaction, then fault while alarm
// RQ18: Preparation takes 250 ms after enabling
// RQ19: No rotation before preparation finishes
// RQ20: Controller waits 250 ms or command ready
// RQ21: Leave not-ready on init completion
// RQ22: Per-error sent flag clears when error goes
module drive_end #(
    parameter int PREP_CYCLES_P = `PREP_CYCLES
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    resetn_in,
    drive_link_if.drive_mp               link,
    input  wire drive_pkg::sync_mode_type sync_mode_in,
    input  wire logic [7:0]              dc_cycle_code_in,
    input  wire logic                    map_bad_in,
    input  wire logic                    map_dir_bad_in,
    input  wire logic                    alarm_in,
    input  wire logic [7:0]              alarm_code_in,
    input  wire logic [7:0]              error_reg_in,
    input  wire logic                    stop_done_in,
    input  wire logic                    op_cmd_in,
    output logic                         app_step_out,
    output logic                         motor_excited_out,
    output logic                         drive_command_ready_out,
    output logic                         rotate_out
);
    import drive_pkg::*;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    drive_state_type state_ff, nxt_state;
    logic [4:0]      init_cnt_ff;
    logic [31:0]     prep_cnt_ff;
    logic [15:0]     free_cnt_ff;
    logic            fr_prev_ff;
    logic            alarm_sent_ff;
    logic            esm_pend_ff;
    logic            emcy_valid_ff;
    emcy_msg_type    emcy_data_ff;
    logic            rotate_ff;
    logic            ack_ff, nak_ff, rej_ff;
    logic [15:0]     sw_ff;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire logic [15:0] cw        = link.control_word;
    wire logic init_done        = (init_cnt_ff == 5'(`INIT_CYCLES));
    wire logic cmd_shutdown     = cw[`CW_QUICK_STOP_N] & cw[`CW_ENABLE_VOLTAGE] & ~cw[`CW_SWITCH_ON];
    wire logic cmd_switch_on    = cw[`CW_QUICK_STOP_N] & cw[`CW_ENABLE_VOLTAGE] & cw[`CW_SWITCH_ON];
    wire logic cmd_enable       = cmd_switch_on & cw[`CW_ENABLE_OP];
    wire logic cmd_disable_v    = ~cw[`CW_ENABLE_VOLTAGE];
    wire logic cmd_quick_stop   = ~cw[`CW_QUICK_STOP_N] & cw[`CW_ENABLE_VOLTAGE];
    wire logic fault_reset_edge = cw[`CW_FAULT_RESET] & ~fr_prev_ff;
    wire logic prep_done        = (prep_cnt_ff >= 32'(PREP_CYCLES_P));
    // Whole milliseconds land on multiples of four quarter-ms units
    wire logic dc_ok            = (dc_cycle_code_in == `DC_CODE_250US) | (dc_cycle_code_in == `DC_CODE_500US) |
                                  ((dc_cycle_code_in >= `DC_CODE_1MS) & (dc_cycle_code_in <= `DC_CODE_10MS) &
                                   (dc_cycle_code_in[1:0] == 2'b00));                           // see RQ4
    wire logic safeop_bad       = ((sync_mode_in == SYNC_SHARED) & ~dc_ok) | map_bad_in | map_dir_bad_in; // see RQ12
    wire logic free_tick        = (free_cnt_ff == 16'(`MIN_CYCLE_CYCLES - 1));

    // ---------------------------------------------------------------
    // Application step selection
    // ---------------------------------------------------------------
    always_comb begin
        unique case (sync_mode_in)
            SYNC_SM2:    app_step_out = link.rx_frame;   // see RQ2
            SYNC_SHARED: app_step_out = link.sync0;      // see RQ5
            default:     app_step_out = free_tick;       // see RQ1
        endcase
    end

    // Own 1 ms tick, independent of the bus
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || free_tick) begin
            free_cnt_ff <= 16'h0000;
        end else begin
            free_cnt_ff <= free_cnt_ff + 16'h0001; // see RQ1
        end
    end

    // ---------------------------------------------------------------
    // Drive state machine
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (alarm_in && (state_ff != ST_NOT_READY) && (state_ff != ST_FAULT) && (state_ff != ST_FAULT_REACT)) begin
            nxt_state = ST_FAULT_REACT;                                    // see RQ17
        end else begin
            unique case (state_ff)
                ST_NOT_READY:   if (init_done) nxt_state = ST_SW_DISABLED; // see RQ21
                ST_SW_DISABLED: if (cmd_shutdown) nxt_state = ST_READY;
                ST_READY: begin
                    if (cmd_disable_v || cmd_quick_stop) nxt_state = ST_SW_DISABLED;
                    else if (cmd_enable) nxt_state = ST_OP_ENABLED;
                    else if (cmd_switch_on) nxt_state = ST_SWITCHED_ON;
                end
                ST_SWITCHED_ON: begin
                    if (cmd_disable_v || cmd_quick_stop) nxt_state = ST_SW_DISABLED;
                    else if (cmd_shutdown) nxt_state = ST_READY;
                    else if (cmd_enable) nxt_state = ST_OP_ENABLED;
                end
                ST_OP_ENABLED: begin
                    if (cmd_disable_v) nxt_state = ST_SW_DISABLED;
                    else if (cmd_quick_stop) nxt_state = ST_QUICK_STOP;    // see RQ16
                    else if (cmd_shutdown) nxt_state = ST_READY;
                    else if (!cw[`CW_ENABLE_OP]) nxt_state = ST_SWITCHED_ON;
                end
                ST_QUICK_STOP:  if (stop_done_in || cmd_disable_v) nxt_state = ST_SW_DISABLED;
                ST_FAULT_REACT: if (stop_done_in) nxt_state = ST_FAULT;    // see RQ17
                ST_FAULT:       if (fault_reset_edge && !alarm_in) nxt_state = ST_SW_DISABLED;
                default:        nxt_state = ST_NOT_READY;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            state_ff    <= ST_NOT_READY;
            init_cnt_ff <= 5'h00;
            fr_prev_ff  <= 1'b0;
        end else begin
            state_ff    <= nxt_state;                     // see RQ13
            fr_prev_ff  <= cw[`CW_FAULT_RESET];
            if (!init_done) init_cnt_ff <= init_cnt_ff + 5'h01;
        end
    end

    // ---------------------------------------------------------------
    // Motor and preparation
    // ---------------------------------------------------------------
    // Excited in op-enabled, quick stop and fault reaction only
    assign motor_excited_out = (state_ff == ST_OP_ENABLED) | (state_ff == ST_QUICK_STOP) |
                               (state_ff == ST_FAULT_REACT);              // see RQ15
    assign drive_command_ready_out = (state_ff == ST_OP_ENABLED) & prep_done; // see RQ18
    assign rotate_out = rotate_ff;

    // Counter saturates so the ready flag holds
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || state_ff != ST_OP_ENABLED) begin
            prep_cnt_ff <= 32'h0000_0000;
            rotate_ff   <= 1'b0;
        end else begin
            if (!prep_done) prep_cnt_ff <= prep_cnt_ff + 32'h0000_0001;   // see RQ18
            // Early commands are dropped, not queued
            if (op_cmd_in && prep_done) rotate_ff <= 1'b1;                 // see RQ19
        end
    end

    // ---------------------------------------------------------------
    // Status word
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            sw_ff <= 16'h0000;
        end else begin
            sw_ff <= 16'h0000;
            sw_ff[`SW_READY]           <= state_ff inside {ST_READY, ST_SWITCHED_ON, ST_OP_ENABLED, ST_QUICK_STOP};
            sw_ff[`SW_SWITCHED_ON]     <= state_ff inside {ST_SWITCHED_ON, ST_OP_ENABLED, ST_QUICK_STOP};
            sw_ff[`SW_OP_ENABLED]      <= state_ff inside {ST_OP_ENABLED, ST_QUICK_STOP};
            sw_ff[`SW_FAULT]           <= state_ff inside {ST_FAULT, ST_FAULT_REACT};
            sw_ff[`SW_VOLTAGE]         <= motor_excited_out;
            sw_ff[`SW_QUICK_STOP_N]    <= (state_ff != ST_QUICK_STOP);
            sw_ff[`SW_SWITCH_DISABLED] <= (state_ff == ST_SW_DISABLED);  // see RQ13
        end
    end
    assign link.status_word = sw_ff;

    // ---------------------------------------------------------------
    // Safe-Op requests and parameter writes
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            ack_ff <= 1'b0;
            nak_ff <= 1'b0;
            rej_ff <= 1'b0;
        end else begin
            ack_ff <= link.safeop_req & ~safeop_bad;
            nak_ff <= link.safeop_req & safeop_bad;                        // see RQ12
            rej_ff <= link.param_wr & (state_ff == ST_NOT_READY);          // see RQ14
        end
    end
    assign link.safeop_ack = ack_ff;
    assign link.safeop_nak = nak_ff;
    assign link.param_rej  = rej_ff;

    // ---------------------------------------------------------------
    // Emergency messages
    // ---------------------------------------------------------------
    // Alarm wins a tie; an ESM report waits in a pending flag
    wire logic alarm_due = alarm_in & ~alarm_sent_ff;                       // see RQ6
    wire logic load     = ~emcy_valid_ff & (alarm_due | esm_pend_ff);
    wire logic taken    = emcy_valid_ff & link.emcy_ready;
    wire emcy_msg_type alarm_msg = {`EMCY_ZERO_BYTE, `EMCY_ZERO_BYTE, `EMCY_ZERO_BYTE, alarm_code_in,
                                    `EMCY_ZERO_BYTE, error_reg_in,
                                    `EMCY_CODE_ALARM};                      // see RQ8 see RQ9 see RQ10
    wire emcy_msg_type esm_msg   = {`EMCY_ZERO_BYTE, `EMCY_ZERO_BYTE, `EMCY_ZERO_BYTE, `EMCY_ZERO_BYTE,
                                    `EMCY_DIAG_FIRST, `EMCY_CHANNEL,
                                    `EMCY_CODE_ESM};                        // see RQ11

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            alarm_sent_ff <= 1'b0;
            esm_pend_ff   <= 1'b0;
            emcy_valid_ff <= 1'b0;
            emcy_data_ff  <= 64'h0000_0000_0000_0000;
        end else begin
            if (!alarm_in) alarm_sent_ff <= 1'b0;                          // see RQ22
            else if (load && alarm_due) alarm_sent_ff <= 1'b1;             // see RQ22
            // New refusal beats the clear of the pending flag
            if (link.safeop_req && safeop_bad) esm_pend_ff <= 1'b1;        // see RQ11
            else if (load && !alarm_due) esm_pend_ff <= 1'b0;
            if (load) begin
                emcy_valid_ff <= 1'b1;
                emcy_data_ff  <= alarm_due ? alarm_msg : esm_msg;          // see RQ7
            end else if (taken) begin
                emcy_valid_ff <= 1'b0;
            end
        end
    end
    assign link.emcy_valid = emcy_valid_ff;
    assign link.emcy_data  = emcy_data_ff;
endmodule

// File: design/ctrl_end.sv
// Controller end: frames, sync pulses, control word, answers
`timescale 1ns/1ns
`include "drive_defines.svh"

module ctrl_end (
    input  wire logic                    ref_clk_in,
    input  wire logic                    resetn_in,
    drive_link_if.ctrl_mp                link,
    input  wire logic [15:0]             cycle_len_in,
    input  wire logic [15:0]             control_word_in,
    input  wire logic                    safeop_req_in,
    input  wire logic                    param_wr_in,
    input  wire logic                    op_cmd_in,
    input  wire logic                    drive_command_ready_in,
    output logic                         op_cmd_out,
    output logic [15:0]                  status_word_out,
    output logic                         emcy_valid_out,
    output drive_pkg::emcy_msg_type      emcy_data_out,
    output logic                         safeop_ack_out,
    output logic                         safeop_nak_out,
    output logic                         param_rej_out
);
    import drive_pkg::*;

    // ---------------------------------------------------------------
    // Cycle generator
    // ---------------------------------------------------------------
    logic [15:0]  cyc_cnt_ff;
    logic [15:0]  cw_ff;
    logic         req_ff, wr_ff;
    logic         emcy_v_ff;
    emcy_msg_type emcy_d_ff;
    logic [15:0]  sw_ff;
    logic         ack_ff, nak_ff, rej_ff;

    // Short requested cycles are stretched to the 1 ms floor
    wire logic [15:0] cyc_len = (cycle_len_in < 16'(`MIN_CYCLE_CYCLES)) ?
                                16'(`MIN_CYCLE_CYCLES) : cycle_len_in;   // see RQ3
    wire logic cyc_end = (cyc_cnt_ff >= cyc_len - 16'h0001);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || cyc_end) begin
            cyc_cnt_ff <= 16'h0000;
        end else begin
            cyc_cnt_ff <= cyc_cnt_ff + 16'h0001;
        end
    end

    // Frame and sync pulse on each cycle boundary
    assign link.rx_frame = cyc_end;
    assign link.sync0    = cyc_end;                                       // see RQ4

    // ---------------------------------------------------------------
    // Control word and requests
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            cw_ff  <= 16'h0000;
            req_ff <= 1'b0;
            wr_ff  <= 1'b0;
        end else begin
            cw_ff  <= control_word_in;                                    // see RQ13
            req_ff <= safeop_req_in;
            wr_ff  <= param_wr_in;
        end
    end
    assign link.control_word = cw_ff;
    assign link.safeop_req   = req_ff;
    assign link.param_wr     = wr_ff;
    // Gate operation commands until the drive is prepared
    assign op_cmd_out = op_cmd_in & drive_command_ready_in;               // see RQ20

    // ---------------------------------------------------------------
    // Answers from the drive
    // ---------------------------------------------------------------
    assign link.emcy_ready = 1'b1;
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            emcy_v_ff <= 1'b0;
            emcy_d_ff <= 64'h0000_0000_0000_0000;
            sw_ff     <= 16'h0000;
            ack_ff    <= 1'b0;
            nak_ff    <= 1'b0;
            rej_ff    <= 1'b0;
        end else begin
            emcy_v_ff <= link.emcy_valid;
            if (link.emcy_valid) emcy_d_ff <= link.emcy_data;
            sw_ff     <= link.status_word;
            ack_ff    <= link.safeop_ack;
            nak_ff    <= link.safeop_nak;
            rej_ff    <= link.param_rej;
        end
    end
    assign emcy_valid_out  = emcy_v_ff;
    assign emcy_data_out   = emcy_d_ff;
    assign status_word_out = sw_ff;
    assign safeop_ack_out  = ack_ff;
    assign safeop_nak_out  = nak_ff;
    assign param_rej_out   = rej_ff;
endmodule

// File: bench/drive_link_props.sv
// Assertions on the drive link
`timescale 1ns/1ns
module drive_link_props (
    input wire logic                    ref_clk_in,
    input wire logic                    resetn_in,
    input wire logic                    rx_frame,
    input wire logic [15:0]             control_word,
    input wire logic [15:0]             status_word,
    input wire logic                    safeop_req,
    input wire logic                    safeop_ack,
    input wire logic                    safeop_nak,
    input wire logic                    param_wr,
    input wire logic                    param_rej,
    input wire logic                    emcy_valid,
    input wire drive_pkg::emcy_msg_type emcy_data
);
    logic [15:0] gap_ff;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);
    // Clocks since last frame, saturating
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in || rx_frame) begin
            gap_ff <= rx_frame && resetn_in ? 16'h0000 : 16'hFFFF;
        end else if (gap_ff != 16'hFFFF) begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end
    a_frame_gap: assert property (rx_frame |-> gap_ff >= 16'h4E1F)
        else $error("frames too close");
    a_req_answered: assert property (safeop_req |=> safeop_ack != safeop_nak)
        else $error("request not answered");
    a_nak_emcy: assert property (safeop_nak |-> ##[1:8] (emcy_valid && emcy_data[15:0] == 16'hA000))
        else $error("refusal without emergency");
    a_esm_bytes: assert property (emcy_valid && emcy_data[15:0] == 16'hA000 |-> emcy_data[63:16] == 48'h0000_0000_0A02)
        else $error("bad refusal bytes");
    a_alarm_bytes: assert property (
        emcy_valid && emcy_data[15:0] != 16'hA000 |->
        emcy_data[15:0] == 16'hFF00 && emcy_data[31:24] == 8'h00 && emcy_data[63:40] == 24'h00_0000)
        else $error("bad alarm bytes");
    a_emcy_once: assert property (emcy_valid |=> !emcy_valid)
        else $error("emergency sent twice");
    a_init_refuse: assert property (param_rej |-> ($past(status_word) & 16'h005F) == 16'h0000)
        else $error("refusal outside init");
    a_op_excited: assert property (status_word[2] |-> status_word[4] && !status_word[6])
        else $error("enabled but cold");
    a_shutdown_ready: assert property (
        status_word[6] && control_word[2:0] == 3'b110 |-> ##[1:4] (status_word[0] || status_word[3]))
        else $error("shutdown stuck");
endmodule

// File: bench/tb_top.sv
// Bench for the drive and controller ends
`timescale 1ns/1ns
module tb_top;
    import drive_pkg::*;
    typedef struct packed {sync_mode_type m; logic [7:0] c; logic mb; logic db; logic nak;} row_type;
    logic          ref_clk_in, resetn_in, map_bad, dir_bad, alarm, stop_done, op_cmd, sreq, pwr;
    logic          step, exc, dcr, rot, op_o, ev, ack, nak, rej;
    logic [2:0]    seen;
    logic [7:0]    code, acode, ereg;
    logic [15:0]   cw, sw;
    sync_mode_type mode;
    emcy_msg_type  ed, last;
    int            error_cnt, comparisons, n_emcy, bad, hits;
    // {mode, code, map bad, dir bad, refused}
    row_type rows[12] = '{13'h1008, 13'h1010, 13'h1020, 13'h1040, 13'h1140, 13'h1019, 13'h1161,
        13'h1001, 13'h1031, 13'h0018, 13'h0825, 13'h0823};
    drive_link_if lnk();
    drive_end #(.PREP_CYCLES_P(20)) u_drive_end (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(lnk.drive_mp),
        .sync_mode_in(mode), .dc_cycle_code_in(code), .map_bad_in(map_bad), .map_dir_bad_in(dir_bad),
        .alarm_in(alarm), .alarm_code_in(acode), .error_reg_in(ereg), .stop_done_in(stop_done), .op_cmd_in(op_cmd),
        .app_step_out(step), .motor_excited_out(exc), .drive_command_ready_out(dcr), .rotate_out(rot));
    ctrl_end u_ctrl_end (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(lnk.ctrl_mp), .cycle_len_in(16'h0000),
        .control_word_in(cw), .safeop_req_in(sreq), .param_wr_in(pwr), .op_cmd_in(op_cmd),
        .drive_command_ready_in(dcr), .op_cmd_out(op_o), .status_word_out(sw), .emcy_valid_out(ev),
        .emcy_data_out(ed), .safeop_ack_out(ack), .safeop_nak_out(nak), .param_rej_out(rej));
    drive_link_props u_drive_link_props (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .rx_frame(lnk.rx_frame),
        .control_word(lnk.control_word), .status_word(lnk.status_word), .safeop_req(lnk.safeop_req),
        .safeop_ack(lnk.safeop_ack), .safeop_nak(lnk.safeop_nak), .param_wr(lnk.param_wr),
        .param_rej(lnk.param_rej), .emcy_valid(lnk.emcy_valid), .emcy_data(lnk.emcy_data));
    // 20 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    // Compare and count
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Four-cycle reset
    task automatic rst;
        resetn_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
    endtask
    // Gather answers and emergencies for n clocks
    task automatic watch(input int n);
        seen = 3'b000;
        n_emcy = 0;
        repeat (n) begin
            @(posedge ref_clk_in);
            seen |= {ack, nak, rej};
            if (ev === 1'b1) begin
                n_emcy++;
                last = ed;
            end
        end
    endtask
    // --------------------
    // Main sequence
    // --------------------
    initial begin
        {resetn_in, map_bad, dir_bad, alarm, stop_done, op_cmd, sreq, pwr} = 8'h00;
        {code, acode, ereg, cw} = 40'h00_0000_0000;
        mode = SYNC_FREE_RUN;
        rst();
        foreach (rows[i]) begin
            @(posedge ref_clk_in);
            {mode, code, map_bad, dir_bad, sreq} <= {rows[i].m, rows[i].c, rows[i].mb, rows[i].db, 1'b1};
            @(posedge ref_clk_in);
            sreq <= 1'b0;
            watch(8);
            chk("answer", 64'({!rows[i].nak, rows[i].nak}), 64'(seen[2:1]));
            chk("emergencies", 64'(rows[i].nak), 64'(n_emcy));
            if (rows[i].nak) chk("refusal message", 64'h0000_0000_0A02_A000, last);
        end
        // Mid-run reset: writes refused while initialising
        rst();
        pwr <= 1'b1;
        @(posedge ref_clk_in);
        pwr <= 1'b0;
        watch(6);
        chk("init refusal", 64'h1, 64'(seen[0]));
        chk("init status", 64'h20, 64'(sw));
        repeat (20) @(posedge ref_clk_in);
        chk("disabled bit", 64'h1, 64'(sw[6]));
        pwr <= 1'b1;
        @(posedge ref_clk_in);
        pwr <= 1'b0;
        watch(6);
        chk("write taken", 64'h0, 64'(seen[0]));
        // Up to op-enabled; command comes before preparation ends
        foreach (rows[k]) if (k < 3) begin
            cw <= k == 0 ? 16'h0006 : k == 1 ? 16'h0007 : 16'h000F;
            op_cmd <= k == 2;
            repeat (8) @(posedge ref_clk_in);
            chk("state bit", 64'h1, 64'(sw[k]));
            chk("excited", 64'(k == 2), 64'(exc));
        end
        chk("early prep", 64'h0, 64'({dcr, rot, op_o}));
        repeat (20) @(posedge ref_clk_in);
        chk("prepared", 64'h7, 64'({dcr, rot, op_o}));
        cw <= 16'h000B;
        repeat (5) @(posedge ref_clk_in);
        chk("quick stop", 64'h2, 64'({exc, sw[5]}));
        // Alarm: one message, excited until stopped
        {alarm, acode, ereg} <= {1'b1, 8'h30, 8'h81};
        watch(10);
        chk("alarm message", 64'h0000_0030_0081_FF00, last);
        chk("alarm count", 64'h1, 64'(n_emcy));
        chk("reacting", 64'h1, 64'(exc));
        stop_done <= 1'b1;
        watch(10);
        chk("fault cold", 64'h1, 64'({exc, sw[3]}));
        chk("no repeat", 64'h0, 64'(n_emcy));
        alarm <= 1'b0;
        @(posedge ref_clk_in);
        alarm <= 1'b1;
        watch(10);
        chk("new alarm", 64'h1, 64'(n_emcy));
        // Steps in each sync mode over one full cycle
        for (int m = 0; m < 3; m++) begin
            mode <= sync_mode_type'(m);
            bad = 0;
            hits = 0;
            repeat (20100) begin
                @(posedge ref_clk_in);
                if (m != 0 && step !== (m == 1 ? lnk.rx_frame : lnk.sync0)) bad++;
                if (step === 1'b1) hits++;
            end
            chk("step source", 64'h0, 64'(bad));
            chk("step seen", 64'h1, 64'(hits > 0));
        end
        close_out();
    end
endmodule
